// ### rtl/test_pattern_frame_timing.sv
`timescale 1ns/1ps
module test_pattern_frame_timing (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // indirect register access
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // video stream toward the transmit path
    output logic frame_start_out,
    output logic frame_end_out,
    output logic line_start_out,
    output logic blank_line_out,
    output logic byte_valid_out,
    output logic byte_last_out,
    output logic [7:0] byte_data_out,
    output logic frame_active_out
);
    typedef struct packed {
        logic [tpg_pkg::REG_COUNT-1:0][7:0] regs;
        tpg_pkg::gen_state_t state;
        logic open;
        logic [15:0] slot;
        logic [15:0] act;
        logic [15:0] tot;
        logic [15:0] bar_w;
        logic [15:0] line_b;
        logic [7:0] vbp;
        logic [7:0] vfp;
        logic [1:0] bsel;
        logic [15:0] byte_pos;
        logic [15:0] bar_pos;
        logic [2:0] bar_idx;
        logic fs;
        logic fe;
        logic ls;
        logic blank;
        logic dv;
        logic last;
        logic [7:0] data;
        logic [7:0] rdata;
    } core_state_t;

    core_state_t st_r;
    core_state_t st_nxt;
    logic en;
    logic [3:0] nbars;
    logic [7:0] cur_color;
    logic [17:0] b1;
    logic [17:0] b2;
    logic [17:0] b3;

    timing_if tm();

    // ----------------------------------------
    // line spacing
    // ----------------------------------------
    rate_tick #(
        .STEP(tpg_pkg::CLK_PERIOD_NS),
        .UNIT(tpg_pkg::SPACING_UNIT_NS)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tk(tm.tick_src)
    );

    line_timer u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .tm(tm.timer)
    );

    assign en = st_r.regs[tpg_pkg::ADDR_CTL[4:0]][tpg_pkg::CTL_ENABLE_BIT];
    assign tm.run = en;
    assign tm.period = {st_r.regs[tpg_pkg::ADDR_LINE_PERIOD_HI[4:0]],
        st_r.regs[tpg_pkg::ADDR_LINE_PERIOD_LO[4:0]]};
    assign nbars = 4'd1 << st_r.bsel;
    assign cur_color = st_r.regs[tpg_pkg::ADDR_COLOR0[4:0] + {2'b00, st_r.bar_idx}];
    assign b1 = {10'd0, st_r.vbp};
    assign b2 = b1 + {2'b00, st_r.act};
    assign b3 = b2 + {10'd0, st_r.vfp};

    // ----------------------------------------
    // registers and frame sequencing
    // ----------------------------------------
    always_comb begin
        logic do_slot;
        logic [17:0] k;
        logic [4:0] idx;
        logic [17:0] v1;
        logic [17:0] v2;
        logic [17:0] v3;
        do_slot = 1'b0;
        k = '0;
        v1 = '0;
        v2 = '0;
        v3 = '0;
        idx = reg_addr_in[4:0];
        st_nxt = st_r;
        st_nxt.fs = 1'b0;
        st_nxt.fe = 1'b0;
        st_nxt.ls = 1'b0;
        st_nxt.blank = 1'b0;
        st_nxt.dv = 1'b0;
        st_nxt.last = 1'b0;
        if (reg_wr_in && reg_addr_in <= tpg_pkg::ADDR_LAST && reg_addr_in != 8'h00
                && reg_addr_in != 8'h03) begin
            st_nxt.regs[idx] = reg_wdata_in;
        end
        if (reg_rd_in) begin
            st_nxt.rdata = (reg_addr_in <= tpg_pkg::ADDR_LAST) ? st_r.regs[idx] : 8'h00;
        end
        if (!en) begin
            // stop at once, closing an open frame
            st_nxt.state = tpg_pkg::ST_IDLE;
            if (st_r.open) begin
                st_nxt.fe = 1'b1;
                st_nxt.open = 1'b0;
            end
        end else begin
            case (st_r.state)
                tpg_pkg::ST_IDLE: begin
                    if (tm.line_strobe) begin
                        st_nxt.act = {st_r.regs[tpg_pkg::ADDR_ACT_LINES_HI[4:0]],
                            st_r.regs[tpg_pkg::ADDR_ACT_LINES_LO[4:0]]};
                        st_nxt.tot = {st_r.regs[tpg_pkg::ADDR_TOT_LINES_HI[4:0]],
                            st_r.regs[tpg_pkg::ADDR_TOT_LINES_LO[4:0]]};
                        st_nxt.bar_w = {st_r.regs[tpg_pkg::ADDR_BAR_WIDTH_HI[4:0]],
                            st_r.regs[tpg_pkg::ADDR_BAR_WIDTH_LO[4:0]]};
                        st_nxt.line_b = {st_r.regs[tpg_pkg::ADDR_LINE_BYTES_HI[4:0]],
                            st_r.regs[tpg_pkg::ADDR_LINE_BYTES_LO[4:0]]};
                        st_nxt.vbp = st_r.regs[tpg_pkg::ADDR_BACK_PORCH[4:0]];
                        st_nxt.vfp = st_r.regs[tpg_pkg::ADDR_FRONT_PORCH[4:0]];
                        st_nxt.bsel = st_r.regs[tpg_pkg::ADDR_CFG[4:0]][tpg_pkg::CFG_BARS_LSB +: 2];
                        st_nxt.fs = 1'b1;
                        st_nxt.open = 1'b1;
                        st_nxt.slot = '0;
                        do_slot = 1'b1;
                    end
                end
                tpg_pkg::ST_FRAME: begin
                    do_slot = tm.line_strobe;
                end
                tpg_pkg::ST_LINE: begin
                    st_nxt.dv = 1'b1;
                    st_nxt.data = cur_color;
                    if ({1'b0, st_r.byte_pos} + 17'd1 >= {1'b0, st_r.line_b}) begin
                        st_nxt.last = 1'b1;
                        st_nxt.state = tpg_pkg::ST_FRAME;
                    end else begin
                        st_nxt.byte_pos = st_r.byte_pos + 16'd1;
                        // the last bar runs to the end of the line
                        if ({1'b0, st_r.bar_idx} != nbars - 4'd1
                                && st_r.bar_pos + 16'd1 == st_r.bar_w) begin
                            st_nxt.bar_idx = st_r.bar_idx + 3'd1;
                            st_nxt.bar_pos = '0;
                        end else begin
                            st_nxt.bar_pos = st_r.bar_pos + 16'd1;
                        end
                    end
                end
                default: begin
                    st_nxt.state = tpg_pkg::ST_IDLE;
                end
            endcase
        end
        if (do_slot) begin
            // bounds from the fresh snapshot, so slot 0 sees this frame's porches
            v1 = {10'd0, st_nxt.vbp};
            v2 = v1 + {2'b00, st_nxt.act};
            v3 = v2 + {10'd0, st_nxt.vfp};
            k = {2'b00, st_nxt.slot};
            st_nxt.state = tpg_pkg::ST_FRAME;
            if (k < v3 && (k < v1 || k >= v2)) begin
                st_nxt.blank = 1'b1;
            end else if (k < v2) begin
                st_nxt.ls = 1'b1;
                if (st_nxt.line_b != 16'd0) begin
                    st_nxt.state = tpg_pkg::ST_LINE;
                    st_nxt.byte_pos = '0;
                    st_nxt.bar_pos = '0;
                    st_nxt.bar_idx = '0;
                end
            end else if (k == v3) begin
                st_nxt.fe = 1'b1;
                st_nxt.open = 1'b0;
            end
            st_nxt.slot = st_nxt.slot + 16'd1;
            // idle lines until the total is reached
            if (k >= v3 && k + 18'd1 >= {2'b00, st_nxt.tot}) begin
                st_nxt.state = tpg_pkg::ST_IDLE;
            end
        end
    end
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.regs <= tpg_pkg::reg_defaults();
            st_r.state <= tpg_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_out = st_r.rdata;
    assign frame_start_out = st_r.fs;
    assign frame_end_out = st_r.fe;
    assign line_start_out = st_r.ls;
    assign blank_line_out = st_r.blank;
    assign byte_valid_out = st_r.dv;
    assign byte_last_out = st_r.last;
    assign byte_data_out = st_r.data;
    assign frame_active_out = st_r.open;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    a_bar_width_first: assert property (
        st_r.state == tpg_pkg::ST_LINE && en && st_r.byte_pos < st_r.bar_w && nbars > 4'd1
        |=> byte_valid_out && byte_data_out == $past(st_r.regs[16]))
        else $error("early byte not in bar zero");
    a_last_bar_end: assert property (
        byte_valid_out && byte_last_out |-> $past(st_r.byte_pos) == st_r.line_b - 16'd1)
        else $error("line ended at the wrong byte");
    a_active_lines_reset: assert property (disable iff (1'b0)
        rst_in |=> {st_r.regs[8], st_r.regs[9]} == 16'd480)
        else $error("active line default wrong");
    a_total_reached: assert property (
        $past(st_r.state) == tpg_pkg::ST_FRAME && st_r.state == tpg_pkg::ST_IDLE && $past(en)
        |-> st_r.slot >= st_r.tot)
        else $error("frame ended before total lines");
    a_period_reset: assert property (disable iff (1'b0)
        rst_in |=> tm.period == 16'd3175)
        else $error("line period default wrong");
    a_back_porch_gap: assert property (
        line_start_out |-> st_r.slot > {8'h00, st_r.vbp})
        else $error("active line inside back porch");
    a_front_porch_end: assert property (
        frame_end_out && $past(en) |-> {2'b00, st_r.slot} == b3 + 18'd1)
        else $error("frame end not after front porch");
    a_bar_width_reset: assert property (disable iff (1'b0)
        rst_in |=> {st_r.regs[6], st_r.regs[7]} == 16'd240)
        else $error("bar width default wrong");
    a_enable_gate: assert property (
        !en |=> !byte_valid_out && !frame_start_out && !line_start_out)
        else $error("output while disabled");
    a_bar_index_range: assert property (
        st_r.state == tpg_pkg::ST_LINE |-> {1'b0, st_r.bar_idx} < nbars)
        else $error("bar index beyond bar count");
    a_bar_color_byte: assert property (
        st_r.state == tpg_pkg::ST_LINE && en |=> byte_data_out == $past(cur_color))
        else $error("byte not from its bar color");
    a_frame_order: assert property (
        (frame_start_out |-> !$past(st_r.open)) and (frame_end_out |-> $past(st_r.open)))
        else $error("frame start or end out of order");
    a_snapshot_hold: assert property (
        st_r.state == tpg_pkg::ST_FRAME |=> st_r.act == $past(st_r.act))
        else $error("frame geometry changed mid frame");
    a_porch_first_slot: assert property (
        frame_start_out && st_r.vbp != 8'h00 |-> blank_line_out && !line_start_out)
        else $error("first slot not a back porch line");
    a_byte_run: assert property (
        byte_valid_out && !byte_last_out && en |=> byte_valid_out)
        else $error("line bytes not consecutive");
    a_last_single: assert property (
        byte_last_out |=> !byte_valid_out)
        else $error("byte after the last byte of a line");
    a_disable_close: assert property (
        !en && st_r.open |=> frame_end_out && !frame_active_out)
        else $error("open frame not closed on disable");
    a_reset_clear: assert property (disable iff (1'b0)
        rst_in |=> !frame_active_out && !byte_valid_out && reg_rdata_out == 8'h00)
        else $error("outputs not cleared by reset");
    a_pulse_in_frame: assert property (
        line_start_out || blank_line_out |-> frame_active_out)
        else $error("line slot outside an open frame");
endmodule

// ### rtl/tpg_pkg.sv
package tpg_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SPACING_UNIT_NS = 10;
    localparam real LINE_TIME_DEFAULT_US = 31.75;
    localparam logic [15:0] LINE_PERIOD_RESET =
        16'(int'(LINE_TIME_DEFAULT_US * 1000.0 / SPACING_UNIT_NS));

    // ----------------------------------------
    // register offsets and fields
    // ----------------------------------------
    localparam int REG_COUNT = 24;
    localparam logic [7:0] ADDR_CTL = 8'h01;
    localparam logic [7:0] ADDR_CFG = 8'h02;
    localparam logic [7:0] ADDR_LINE_BYTES_HI = 8'h04;
    localparam logic [7:0] ADDR_LINE_BYTES_LO = 8'h05;
    localparam logic [7:0] ADDR_BAR_WIDTH_HI = 8'h06;
    localparam logic [7:0] ADDR_BAR_WIDTH_LO = 8'h07;
    localparam logic [7:0] ADDR_ACT_LINES_HI = 8'h08;
    localparam logic [7:0] ADDR_ACT_LINES_LO = 8'h09;
    localparam logic [7:0] ADDR_TOT_LINES_HI = 8'h0A;
    localparam logic [7:0] ADDR_TOT_LINES_LO = 8'h0B;
    localparam logic [7:0] ADDR_LINE_PERIOD_HI = 8'h0C;
    localparam logic [7:0] ADDR_LINE_PERIOD_LO = 8'h0D;
    localparam logic [7:0] ADDR_BACK_PORCH = 8'h0E;
    localparam logic [7:0] ADDR_FRONT_PORCH = 8'h0F;
    localparam logic [7:0] ADDR_COLOR0 = 8'h10;
    localparam logic [7:0] ADDR_LAST = 8'h17;
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CFG_BARS_LSB = 4;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] RST_CTL = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h33;
    localparam logic [7:0] RST_LINE_BYTES_HI = 8'h07;
    localparam logic [7:0] RST_LINE_BYTES_LO = 8'h80;
    localparam logic [7:0] RST_BAR_WIDTH_HI = 8'h00;
    localparam logic [7:0] RST_BAR_WIDTH_LO = 8'hF0;
    localparam logic [7:0] RST_ACT_LINES_HI = 8'h01;
    localparam logic [7:0] RST_ACT_LINES_LO = 8'hE0;
    localparam logic [7:0] RST_TOT_LINES_HI = 8'h02;
    localparam logic [7:0] RST_TOT_LINES_LO = 8'h0D;
    localparam logic [7:0] RST_BACK_PORCH = 8'h0A;
    localparam logic [7:0] RST_FRONT_PORCH = 8'h0A;
    localparam logic [0:7][7:0] RST_COLORS = {
        8'hAA, 8'h33, 8'hF0, 8'h7F, 8'h55, 8'hCC, 8'h0F, 8'h80};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_FRAME = 3'b010,
        ST_LINE = 3'b100
    } gen_state_t;

    function automatic logic [REG_COUNT-1:0][7:0] reg_defaults();
        logic [REG_COUNT-1:0][7:0] r;
        r = '0;
        r[ADDR_CTL[4:0]] = RST_CTL;
        r[ADDR_CFG[4:0]] = RST_CFG;
        r[ADDR_LINE_BYTES_HI[4:0]] = RST_LINE_BYTES_HI;
        r[ADDR_LINE_BYTES_LO[4:0]] = RST_LINE_BYTES_LO;
        r[ADDR_BAR_WIDTH_HI[4:0]] = RST_BAR_WIDTH_HI;
        r[ADDR_BAR_WIDTH_LO[4:0]] = RST_BAR_WIDTH_LO;
        r[ADDR_ACT_LINES_HI[4:0]] = RST_ACT_LINES_HI;
        r[ADDR_ACT_LINES_LO[4:0]] = RST_ACT_LINES_LO;
        r[ADDR_TOT_LINES_HI[4:0]] = RST_TOT_LINES_HI;
        r[ADDR_TOT_LINES_LO[4:0]] = RST_TOT_LINES_LO;
        r[ADDR_LINE_PERIOD_HI[4:0]] = LINE_PERIOD_RESET[15:8];
        r[ADDR_LINE_PERIOD_LO[4:0]] = LINE_PERIOD_RESET[7:0];
        r[ADDR_BACK_PORCH[4:0]] = RST_BACK_PORCH;
        r[ADDR_FRONT_PORCH[4:0]] = RST_FRONT_PORCH;
        for (int i = 0; i < 8; i++) begin
            r[ADDR_COLOR0[4:0] + 5'(i)] = RST_COLORS[i];
        end
        return r;
    endfunction

endpackage

// ### rtl/timing_if.sv
`timescale 1ns/1ps
interface timing_if;
    logic run;
    logic tick;
    logic [15:0] period;
    logic line_strobe;

    modport ctrl(output run, output period, input line_strobe);
    modport tick_src(input run, output tick);
    modport timer(input run, input tick, input period, output line_strobe);
endinterface

// ### rtl/rate_tick.sv
`timescale 1ns/1ps
module rate_tick #(
    parameter int STEP = 8,
    parameter int UNIT = 10
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // tick toward the line timer
    timing_if.tick_src tk
);
    localparam int W = $clog2(STEP + UNIT);

    typedef struct packed {
        logic [W-1:0] acc;
        logic tick;
    } tick_state_t;

    tick_state_t st_r;
    tick_state_t st_nxt;

    // ----------------------------------------
    // fractional accumulator, one pulse per unit
    // ----------------------------------------
    always_comb begin
        int sum;
        sum = int'(st_r.acc) + STEP;
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (!tk.run) begin
            st_nxt.acc = '0;
        end else if (sum >= UNIT) begin
            st_nxt.acc = W'(sum - UNIT);
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.acc = W'(sum);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tk.tick = st_r.tick;
endmodule

// ### rtl/line_timer.sv
`timescale 1ns/1ps
module line_timer (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // period in, strobe out
    timing_if.timer tm
);
    typedef struct packed {
        logic [15:0] cnt;
        logic strobe;
    } timer_state_t;

    timer_state_t st_r;
    timer_state_t st_nxt;

    // ----------------------------------------
    // count unit ticks up to the line period
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.strobe = 1'b0;
        if (!tm.run) begin
            st_nxt.cnt = '0;
        end else if (tm.tick) begin
            if ({1'b0, st_r.cnt} + 17'd1 >= {1'b0, tm.period}) begin
                st_nxt.cnt = '0;
                st_nxt.strobe = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 16'd1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tm.line_strobe = st_r.strobe;

    a_strobe_gap: assert property (@(posedge core_clk_in) disable iff (rst_in)
        tm.line_strobe |=> !tm.line_strobe)
        else $error("line strobe lasted more than one cycle");
endmodule

// ### verification/stream_sink.sv
`timescale 1ns/1ps
module stream_sink (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // stream from the generator
    input wire logic frame_start_in,
    input wire logic frame_end_in,
    input wire logic line_start_in,
    input wire logic blank_line_in,
    input wire logic byte_valid_in,
    input wire logic byte_last_in,
    input wire logic [7:0] byte_data_in,
    // what the receiver saw
    output logic [15:0] last_at_out,
    output logic [0:15][7:0] line_buf_out,
    output logic [7:0] frame_seq_out,
    output logic [15:0] frames_out,
    output logic [15:0] pulses_out,
    output logic [15:0] frame_gap_out,
    output logic [15:0] slot_gap_out
);
    logic [15:0] cyc_r;
    logic [15:0] cnt_r;
    logic [15:0] fs_at_r;
    logic [15:0] slot_at_r;
    logic [7:0] seq_r;

    // marker bit at frame start, then one bit per slot: 1 active, 0 blank
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            {cyc_r, cnt_r, fs_at_r, slot_at_r, seq_r} <= '0;
            {last_at_out, line_buf_out, frame_seq_out, frames_out} <= '0;
            {pulses_out, frame_gap_out, slot_gap_out} <= '0;
        end else begin
            cyc_r <= cyc_r + 16'h0001;
            if (frame_start_in) begin
                frame_gap_out <= cyc_r - fs_at_r;
                fs_at_r <= cyc_r;
            end
            if (line_start_in || blank_line_in) begin
                seq_r <= {(frame_start_in ? 7'h01 : seq_r[6:0]), line_start_in};
                slot_gap_out <= cyc_r - slot_at_r;
                slot_at_r <= cyc_r;
                pulses_out <= pulses_out + 16'h0001;
            end
            if (line_start_in) begin
                cnt_r <= '0;
            end
            if (byte_valid_in) begin
                line_buf_out[cnt_r[3:0]] <= byte_data_in;
                cnt_r <= cnt_r + 16'h0001;
            end
            if (byte_last_in) begin
                last_at_out <= cnt_r + 16'h0001;
            end
            if (frame_end_in) begin
                frame_seq_out <= seq_r;
                frames_out <= frames_out + 16'h0001;
            end
        end
    end
endmodule

// ### verification/test_test_pattern_frame_timing.sv
`timescale 1ns/1ps
module test_test_pattern_frame_timing;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic frame_start_out, frame_end_out, line_start_out, blank_line_out;
    logic byte_valid_out, byte_last_out, frame_active_out;
    logic [7:0] byte_data_out;
    logic [15:0] last_at, frames, pulses, frame_gap, slot_gap;
    logic [0:15][7:0] line_buf;
    logic [7:0] frame_seq;
    int fail_count = 0;
    int compares = 0;

    // addr, reset value
    localparam logic [15:0] rst_rows [14] = '{16'h0600, 16'h07F0, 16'h0801, 16'h09E0,
        16'h0A02, 16'h0B0D, 16'h0C0C, 16'h0D67, 16'h0E0A, 16'h0F0A, 16'h0000, 16'h1800,
        16'h10AA, 16'h0100};
    // line 10 bytes, 2 active, 8 total, 20 units, porch 1 and 2
    localparam logic [15:0] setup_rows [11] = '{16'h0400, 16'h050A, 16'h0800, 16'h0902,
        16'h0A00, 16'h0B08, 16'h0C00, 16'h0D14, 16'h0E01, 16'h0F02, 16'h185A};
    // bar count code, bar width
    localparam logic [17:0] rows [6] = '{18'h00003, 18'h10003, 18'h20003, 18'h30003,
        18'h30002, 18'h10100};

    always #4 core_clk_in = ~core_clk_in;

    test_pattern_frame_timing dut (.core_clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
        .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .frame_start_out, .frame_end_out,
        .line_start_out, .blank_line_out, .byte_valid_out, .byte_last_out, .byte_data_out,
        .frame_active_out);

    stream_sink sink (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .frame_start_in(frame_start_out), .frame_end_in(frame_end_out),
        .line_start_in(line_start_out), .blank_line_in(blank_line_out),
        .byte_valid_in(byte_valid_out), .byte_last_in(byte_last_out),
        .byte_data_in(byte_data_out), .last_at_out(last_at), .line_buf_out(line_buf),
        .frame_seq_out(frame_seq), .frames_out(frames), .pulses_out(pulses),
        .frame_gap_out(frame_gap), .slot_gap_out(slot_gap));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("register read", {a, exp}, {a, reg_rdata_out});
    endtask

    task automatic wait_last();
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge core_clk_in);
            #1;
            if (byte_last_out === 1'b1) break;
        end
        if (n == 400) chk("line wait", 16'h0001, 16'h0000);
        @(posedge core_clk_in);
        #1;
    endtask

    function automatic logic [7:0] exp_byte(input int code, input int bw, input int i);
        int b;
        b = (bw == 0) ? 0 : i / bw;
        if (b > (1 << code) - 1) b = (1 << code) - 1;
        return tpg_pkg::RST_COLORS[b];
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] f0;
        int n;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        // ----------------------------------------
        // reset values and register access
        // ----------------------------------------
        foreach (rst_rows[k]) rdchk(rst_rows[k][15:8], rst_rows[k][7:0]);
        chk("idle frame", 16'h0000, {15'h0000, frame_active_out});
        foreach (setup_rows[k]) wr(setup_rows[k][15:8], setup_rows[k][7:0]);
        rdchk(8'h18, 8'h00);
        rdchk(8'h0D, 8'h14);
        rdchk(8'h05, 8'h0A);
        // ----------------------------------------
        // bar layout for each bar count
        // ----------------------------------------
        foreach (rows[r]) begin
            wr(8'h01, 8'h00);
            wr(8'h02, {2'b00, rows[r][17:16], 4'h3});
            wr(8'h06, rows[r][15:8]);
            wr(8'h07, rows[r][7:0]);
            wr(8'h01, 8'h01);
            wait_last();
            chk("line length", 16'd10, last_at);
            for (n = 0; n < 10; n++) begin
                chk("bar byte", {8'h00, exp_byte(rows[r][17:16], rows[r][15:0], n)},
                    {8'h00, line_buf[n]});
            end
        end
        // ----------------------------------------
        // frame order and spacing
        // ----------------------------------------
        f0 = frames;
        for (n = 0; n < 1000 && frames < f0 + 16'd2; n++) @(posedge core_clk_in);
        #1;
        if (n == 1000) chk("frame wait", 16'h0001, 16'h0000);
        chk("frame order", 16'h002C, {8'h00, frame_seq});
        chk("frame gap", 16'd200, frame_gap);
        chk("line gap", 16'd25, slot_gap);
        // ----------------------------------------
        // disable in mid-frame
        // ----------------------------------------
        wait_last();
        f0 = frames;
        wr(8'h01, 8'h00);
        repeat (2) @(posedge core_clk_in);
        #1;
        chk("off frame end", f0 + 16'd1, frames);
        f0 = pulses;
        chk("off stream", 16'h0000, {14'h0000, frame_active_out, byte_valid_out});
        repeat (60) @(posedge core_clk_in);
        #1;
        chk("off pulses", f0, pulses);
        // ----------------------------------------
        // reset in mid-frame
        // ----------------------------------------
        wr(8'h01, 8'h01);
        wait_last();
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk("reset stream", 16'h0000, {14'h0000, frame_active_out, byte_valid_out});
        foreach (rst_rows[k]) rdchk(rst_rows[k][15:8], rst_rows[k][7:0]);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge core_clk_in);
        fail_count++;
        final_report();
    end
endmodule
